// *** common/tmr8_pkg.sv ***
/*
 tmr8 package: register offsets, field positions, reset values and mode codes
 for the 8-bit timer with clear-on-match and two PWM modes.
 assumes a classic Wishbone slave with 32-bit data and byte addresses.
*/
`default_nettype none
package tmr8_pkg;
    localparam int unsigned TMR8_AW = 5;
    // byte addresses of the register words
    localparam logic [4:0] TMR8_CTRL_OFS = 5'h00;
    localparam logic [4:0] TMR8_CNT_OFS = 5'h04;
    localparam logic [4:0] TMR8_CMPA_OFS = 5'h08;
    localparam logic [4:0] TMR8_CMPB_OFS = 5'h0C;
    localparam logic [4:0] TMR8_FLAG_OFS = 5'h10;
    localparam logic [4:0] TMR8_DIR_OFS = 5'h14;
    // control word fields
    localparam int unsigned TMR8_MODE_LSB = 0;
    localparam int unsigned TMR8_PRE_LSB = 4;
    localparam int unsigned TMR8_ACTB_LSB = 8;
    localparam int unsigned TMR8_ACTA_LSB = 10;
    // flag word fields
    localparam int unsigned TMR8_FLG_OVF = 0;
    localparam int unsigned TMR8_FLG_CMPA = 1;
    localparam int unsigned TMR8_FLG_CMPB = 2;
    localparam logic [7:0] TMR8_BOTTOM = 8'h00;
    localparam logic [7:0] TMR8_MAX = 8'hFF;
    localparam logic [7:0] TMR8_ZERO8 = 8'h00;
    localparam logic [31:0] TMR8_ZERO32 = 32'h0000_0000;
    // waveform mode select codes
    localparam logic [2:0] TMR8_M_PC8 = 3'h1;
    localparam logic [2:0] TMR8_M_CTC = 3'h2;
    localparam logic [2:0] TMR8_M_FAST8 = 3'h3;
    localparam logic [2:0] TMR8_M_PCA = 3'h5;
    localparam logic [2:0] TMR8_M_FASTA = 3'h7;
    // output action codes
    localparam logic [1:0] TMR8_ACT_OFF = 2'h0;
    localparam logic [1:0] TMR8_ACT_TGL = 2'h1;
    localparam logic [1:0] TMR8_ACT_CLR = 2'h2;
    localparam logic [1:0] TMR8_ACT_SET = 2'h3;
    // prescale select codes and divide counts
    localparam logic [2:0] TMR8_PRE_STOP = 3'h0;
    localparam logic [2:0] TMR8_PRE_1 = 3'h1;
    localparam logic [2:0] TMR8_PRE_8 = 3'h2;
    localparam logic [2:0] TMR8_PRE_64 = 3'h3;
    localparam logic [2:0] TMR8_PRE_256 = 3'h4;
    localparam logic [2:0] TMR8_PRE_1024 = 3'h5;
    localparam logic [9:0] TMR8_DIV_8 = 10'h007;
    localparam logic [9:0] TMR8_DIV_64 = 10'h03F;
    localparam logic [9:0] TMR8_DIV_256 = 10'h0FF;
    localparam logic [9:0] TMR8_DIV_1024 = 10'h3FF;
    localparam logic [9:0] TMR8_DIV_ONE = 10'h001;
    localparam logic [9:0] TMR8_DIV_CLR = 10'h000;
    typedef enum logic [1:0] {
        TMR8_DIR_UP = 2'b00,
        TMR8_DIR_DOWN = 2'b01
    } tmr8_dir_e;
endpackage
`default_nettype wire

// *** rtl/tmr8_core.sv ***
/*
 tmr8_core: 8-bit timer/counter with clear-on-match, fast PWM and
 phase-correct PWM, two waveform outputs and a Wishbone register port.
 assumes one clock, a synchronous reset and a classic Wishbone master.
*/
`default_nettype none
// Contract
// - mode 2 clears counter after compare A match
// - clear-on-match compare A writes act immediately
// - clear-on-match sets compare A flag at top
// - action 1 toggles output A on match
// - output drives pin only when direction output
// - clear-on-match overflow set stepping max to zero
// - modes 3/7 single-slope, top FF or compare A
// - fast PWM action 2/3 match and bottom polarity
// - fast PWM clears counter cycle after top
// - fast PWM overflow flag set at top
// - PWM toggle on A only with mode high bit
// - PWM compare writes double buffered until counter reaches top
// - fast PWM extremes: spike or constant level
// - modes 1/5 dual-slope, top FF or compare A
// - phase-correct match polarity depends on direction
// - phase-correct reverses at top with no hold cycle
// - phase-correct overflow flag set at bottom
// - phase-correct extremes give constant levels
// - phase-correct symmetric output without match
// - prescale selectable 1, 8, 64, 256, 1024
// - match flag next cycle, write one clears
// - counter write blocks matches next timer cycle
// - reset clears both output latches
module tmr8_core
    import tmr8_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [TMR8_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wave_output_a_o,
    output logic wave_output_a_oe_n_o,
    output logic wave_output_b_o,
    output logic wave_output_b_oe_n_o,
    output logic overflow_flag_o,
    output logic compare_a_match_flag_o,
    output logic compare_b_match_flag_o
);
    logic [2:0] mode_q;
    logic [2:0] pre_q;
    logic [1:0] act_a_q;
    logic [1:0] act_b_q;
    logic [1:0] dir_en_q;
    logic [7:0] cnt_q;
    logic [7:0] cmp_a_q;
    logic [7:0] cmp_b_q;
    logic [7:0] buf_a_q;
    logic [7:0] buf_b_q;
    logic [9:0] div_q;
    logic [2:0] flag_q;
    logic out_a_q;
    logic out_b_q;
    logic blk_q;
    logic ack_q;
    logic [31:0] rd_q;
    tmr8_dir_e dir_q;

    // bus decode
    wire bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    wire bus_wr = bus_req && wb_we_i;
    wire sel_ctrl = wb_adr_i == TMR8_CTRL_OFS;
    wire sel_cnt = wb_adr_i == TMR8_CNT_OFS;
    wire sel_cmpa = wb_adr_i == TMR8_CMPA_OFS;
    wire sel_cmpb = wb_adr_i == TMR8_CMPB_OFS;
    wire sel_flag = wb_adr_i == TMR8_FLAG_OFS;
    wire sel_dir = wb_adr_i == TMR8_DIR_OFS;
    wire wr_ctrl0 = bus_wr && sel_ctrl && wb_sel_i[0];
    wire wr_ctrl1 = bus_wr && sel_ctrl && wb_sel_i[1];
    wire wr_cnt = bus_wr && sel_cnt && wb_sel_i[0];
    wire wr_cmpa = bus_wr && sel_cmpa && wb_sel_i[0];
    wire wr_cmpb = bus_wr && sel_cmpb && wb_sel_i[0];
    wire wr_flag = bus_wr && sel_flag && wb_sel_i[0];
    wire wr_dir = bus_wr && sel_dir && wb_sel_i[0];

    // mode decode
    wire is_ctc = mode_q == TMR8_M_CTC;
    wire is_fast = (mode_q == TMR8_M_FAST8) || (mode_q == TMR8_M_FASTA);
    wire is_pc = (mode_q == TMR8_M_PC8) || (mode_q == TMR8_M_PCA);
    wire is_pwm = is_fast || is_pc;
    wire top_is_a = (mode_q == TMR8_M_FASTA) || (mode_q == TMR8_M_PCA);
    wire mode_hi = mode_q[2];

    // prescaled timer enable
    logic [9:0] div_lim;
    always_comb begin
        case (pre_q)
            TMR8_PRE_8: div_lim = TMR8_DIV_8;
            TMR8_PRE_64: div_lim = TMR8_DIV_64;
            TMR8_PRE_256: div_lim = TMR8_DIV_256;
            TMR8_PRE_1024: div_lim = TMR8_DIV_1024;
            default: div_lim = TMR8_DIV_CLR;
        endcase
    end
    wire run = pre_q != TMR8_PRE_STOP;
    wire tick = run && (div_q == div_lim);

    // counting
    wire [7:0] top = (top_is_a || is_ctc) ? cmp_a_q : TMR8_MAX;
    wire at_top = cnt_q == top;
    wire at_bot = cnt_q == TMR8_BOTTOM;
    wire at_max = cnt_q == TMR8_MAX;
    wire match_a = (cnt_q == cmp_a_q) && !blk_q;
    wire match_b = (cnt_q == cmp_b_q) && !blk_q;
    wire pc_turn_dn = is_pc && dir_q == TMR8_DIR_UP && at_top;
    wire pc_turn_up = is_pc && dir_q == TMR8_DIR_DOWN && at_bot;
    wire going_up = (dir_q == TMR8_DIR_UP) && !at_top;
    wire fast_wrap = is_fast && at_top;
    wire ctc_wrap = is_ctc && match_a;
    wire pc_step_up = is_pc && (pc_turn_up || going_up);

    logic [7:0] cnt_nx;
    always_comb begin
        if (ctc_wrap || fast_wrap) begin
            cnt_nx = TMR8_BOTTOM;
        end else if (is_ctc || pc_step_up) begin
            cnt_nx = cnt_q + 8'h01;
        end else if (is_pc) begin
            cnt_nx = cnt_q - 8'h01;
        end else if (is_fast) begin
            cnt_nx = cnt_q + 8'h01;
        end else begin
            cnt_nx = cnt_q;
        end
    end

    // direction update for dual slope
    tmr8_dir_e dir_nx;
    always_comb begin
        if (pc_turn_dn) begin
            dir_nx = TMR8_DIR_DOWN;
        end else if (pc_turn_up || !is_pc) begin
            dir_nx = TMR8_DIR_UP;
        end else begin
            dir_nx = dir_q;
        end
    end

    // counter at top loads the double buffers
    wire reload = (is_fast && at_top) || (is_pc && at_top && dir_q == TMR8_DIR_UP);

    // flags
    wire ovf_ev = (is_ctc && at_max && !ctc_wrap) || (is_fast && at_top) || (is_pc && pc_turn_up);
    wire [2:0] flag_set = {match_b, match_a, ovf_ev} & {3{tick}};
    wire [2:0] flag_clr = wr_flag ? wb_dat_i[2:0] : 3'h0;

    // waveform latches
    function automatic logic wave_nx(input logic cur, input logic [1:0] act, input logic hit,
                                     input logic tgl_ok, input logic eq_top);
        logic r;
        r = cur;
        if (is_ctc) begin
            if (hit && act == TMR8_ACT_TGL) r = !cur;
            else if (hit && act == TMR8_ACT_CLR) r = 1'b0;
            else if (hit && act == TMR8_ACT_SET) r = 1'b1;
        end else if (is_fast) begin
            if (act == TMR8_ACT_TGL) begin
                if (hit && tgl_ok) r = !cur;
            end else if (act[1]) begin
                if (at_top) r = !act[0];
                else if (hit && !eq_top) r = act[0];
            end
        end else if (is_pc) begin
            if (act == TMR8_ACT_TGL) begin
                if (hit && tgl_ok) r = !cur;
            end else if (act[1]) begin
                if (eq_top && at_top && dir_q == TMR8_DIR_UP) r = !act[0];
                else if (hit && at_bot) r = act[0];
                else if (hit && dir_q == TMR8_DIR_UP && !eq_top) r = act[0];
                else if (hit && dir_q == TMR8_DIR_DOWN) r = !act[0];
                else if (pc_turn_dn && !eq_top && cnt_q > 8'h00 && r != act[0]) r = act[0];
            end
        end
        return r;
    endfunction

    wire a_eq_top = cmp_a_q == top;
    wire b_eq_top = cmp_b_q == top;
    wire out_a_nx = wave_nx(out_a_q, act_a_q, match_a, mode_hi, a_eq_top);
    wire out_b_nx = wave_nx(out_b_q, act_b_q, match_b, 1'b0, b_eq_top);

    // register read mux
    logic [31:0] rd_d;
    always_comb begin
        rd_d = TMR8_ZERO32;
        if (sel_ctrl) rd_d = {20'h0, act_a_q, act_b_q, 1'b0, pre_q, 1'b0, mode_q};
        else if (sel_cnt) rd_d = {24'h0, cnt_q};
        else if (sel_cmpa) rd_d = {24'h0, is_pwm ? buf_a_q : cmp_a_q};
        else if (sel_cmpb) rd_d = {24'h0, is_pwm ? buf_b_q : cmp_b_q};
        else if (sel_flag) rd_d = {29'h0, flag_q};
        else if (sel_dir) rd_d = {28'h0, out_b_q, out_a_q, dir_en_q};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rd_q <= TMR8_ZERO32;
        end else begin
            ack_q <= bus_req;
            rd_q <= rd_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= 3'h0;
            pre_q <= TMR8_PRE_STOP;
            act_a_q <= TMR8_ACT_OFF;
            act_b_q <= TMR8_ACT_OFF;
            dir_en_q <= 2'h0;
        end else begin
            if (wr_ctrl0) mode_q <= wb_dat_i[TMR8_MODE_LSB +: 3];
            if (wr_ctrl0) pre_q <= wb_dat_i[TMR8_PRE_LSB +: 3];
            if (wr_ctrl1) act_b_q <= wb_dat_i[TMR8_ACTB_LSB +: 2];
            if (wr_ctrl1) act_a_q <= wb_dat_i[TMR8_ACTA_LSB +: 2];
            if (wr_dir) dir_en_q <= wb_dat_i[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !run) div_q <= TMR8_DIV_CLR;
        else div_q <= tick ? TMR8_DIV_CLR : div_q + TMR8_DIV_ONE;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= TMR8_ZERO8;
            dir_q <= TMR8_DIR_UP;
            blk_q <= 1'b0;
        end else begin
            if (wr_cnt) cnt_q <= wb_dat_i[7:0];
            else if (tick) cnt_q <= cnt_nx;
            if (tick) dir_q <= dir_nx;
            if (wr_cnt) blk_q <= 1'b1;
            else if (tick) blk_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_a_q <= TMR8_ZERO8;
            cmp_b_q <= TMR8_ZERO8;
            buf_a_q <= TMR8_ZERO8;
            buf_b_q <= TMR8_ZERO8;
        end else begin
            if (wr_cmpa) buf_a_q <= wb_dat_i[7:0];
            if (wr_cmpb) buf_b_q <= wb_dat_i[7:0];
            if (wr_cmpa && !is_pwm) cmp_a_q <= wb_dat_i[7:0];
            else if (tick && reload) cmp_a_q <= buf_a_q;
            if (wr_cmpb && !is_pwm) cmp_b_q <= wb_dat_i[7:0];
            else if (tick && reload) cmp_b_q <= buf_b_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= 3'h0;
            out_a_q <= 1'b0;
            out_b_q <= 1'b0;
        end else begin
            flag_q <= (flag_q & ~flag_clr) | flag_set;
            if (tick) out_a_q <= out_a_nx;
            if (tick) out_b_q <= out_b_nx;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rd_q;
    assign wave_output_a_o = out_a_q;
    assign wave_output_b_o = out_b_q;
    assign wave_output_a_oe_n_o = !(dir_en_q[0] && act_a_q != TMR8_ACT_OFF);
    assign wave_output_b_oe_n_o = !(dir_en_q[1] && act_b_q != TMR8_ACT_OFF);
    assign overflow_flag_o = flag_q[TMR8_FLG_OVF];
    assign compare_a_match_flag_o = flag_q[TMR8_FLG_CMPA];
    assign compare_b_match_flag_o = flag_q[TMR8_FLG_CMPB];
endmodule
`default_nettype wire

// *** testbench/tmr8_core_monitor.sv ***
/*
 tmr8_mon: port-level assertions for tmr8_core.
 assumes it is bound onto tmr8_core; one clock, synchronous reset.
*/
`default_nettype none
module tmr8_mon
    import tmr8_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [TMR8_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wave_output_a_o,
    input wire logic wave_output_a_oe_n_o,
    input wire logic wave_output_b_o,
    input wire logic wave_output_b_oe_n_o,
    input wire logic overflow_flag_o,
    input wire logic compare_a_match_flag_o,
    input wire logic compare_b_match_flag_o
);
    logic [11:0] ctl_q;
    logic [7:0] cmpa_q;
    logic [1:0] dir_q;
    logic [8:0] run_q;
    wire take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    wire clr = take && wb_adr_i == TMR8_FLAG_OFS;
    wire tgl_cfg = ctl_q == 12'h412 && cmpa_q == 8'h00;
    // shadow copies of control, compare a and direction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_q <= 12'h000;
            cmpa_q <= 8'h00;
            dir_q <= 2'h0;
        end else if (take) begin
            if (wb_adr_i == TMR8_CTRL_OFS) ctl_q <= wb_dat_i[11:0];
            if (wb_adr_i == TMR8_CMPA_OFS) cmpa_q <= wb_dat_i[7:0];
            if (wb_adr_i == TMR8_DIR_OFS) dir_q <= wb_dat_i[1:0];
        end
    end
    // cycles spent in the fastest clear-on-match toggle setup
    always_ff @(posedge clk_i) begin
        if (rst_i || take || !tgl_cfg) run_q <= 9'h000;
        else if (run_q != 9'h1FF) run_q <= run_q + 9'h001;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_rst_latch; disable iff (1'b0) rst_i |=> !wave_output_a_o && !wave_output_b_o; endproperty
    a_rst_latch: assert property (p_rst_latch) else $error("latch not cleared by reset");
    property p_pin_en; (!wave_output_a_oe_n_o) == (dir_q[0] && ctl_q[11:10] != 2'h0)
        && (!wave_output_b_oe_n_o) == (dir_q[1] && ctl_q[9:8] != 2'h0); endproperty
    a_pin_en: assert property (p_pin_en) else $error("pin enable wrong");
    property p_ovf_hold; overflow_flag_o && !(clr && wb_dat_i[0]) |=> overflow_flag_o; endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag lost");
    property p_fa_hold; compare_a_match_flag_o && !(clr && wb_dat_i[1]) |=> compare_a_match_flag_o; endproperty
    a_fa_hold: assert property (p_fa_hold) else $error("match a flag lost");
    property p_fb_hold; compare_b_match_flag_o && !(clr && wb_dat_i[2]) |=> compare_b_match_flag_o; endproperty
    a_fb_hold: assert property (p_fb_hold) else $error("match b flag lost");
    property p_ctc_tgl; run_q > 9'h140 |-> wave_output_a_o != $past(wave_output_a_o); endproperty
    a_ctc_tgl: assert property (p_ctc_tgl) else $error("no toggle every cycle");
    property p_stop; ctl_q[6:4] == TMR8_PRE_STOP && $past(ctl_q[6:4], 2) == TMR8_PRE_STOP
        |-> !$rose(overflow_flag_o); endproperty
    a_stop: assert property (p_stop) else $error("overflow while stopped");
endmodule
bind tmr8_core tmr8_mon u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wave_output_a_o(wave_output_a_o), .wave_output_a_oe_n_o(wave_output_a_oe_n_o),
    .wave_output_b_o(wave_output_b_o), .wave_output_b_oe_n_o(wave_output_b_oe_n_o),
    .overflow_flag_o(overflow_flag_o), .compare_a_match_flag_o(compare_a_match_flag_o),
    .compare_b_match_flag_o(compare_b_match_flag_o));
`default_nettype wire

// *** testbench/timer8_ctc_pwm_modes_tb_top.sv ***
/*
 timer8_ctc_pwm_modes_tb_top: self-checking bench for tmr8_core.
 assumes the tmr8_mon checker is bound in; checks are bus read-backs plus direct pin checks.
*/
`default_nettype none
module timer8_ctc_pwm_modes_tb_top
    import tmr8_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic wave_a;
    logic wave_b;
    logic oe_a_n;
    logic oe_b_n;
    logic ovf;
    logic flag_a;
    int errors = 0;
    int checks = 0;
    logic [31:0] expq[$];
    logic [31:0] rng = 32'h49;
    logic [2:0] modes[4] = '{TMR8_M_PC8, TMR8_M_FAST8, TMR8_M_PCA, TMR8_M_FASTA};

    tmr8_core DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wave_output_a_o(wave_a), .wave_output_a_oe_n_o(oe_a_n), .wave_output_b_o(wave_b),
        .wave_output_b_oe_n_o(oe_b_n), .overflow_flag_o(ovf), .compare_a_match_flag_o(flag_a),
        .compare_b_match_flag_o());

    always #25 clk_i = ~clk_i;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // one classic cycle, entered just after an edge
    task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 64);
        if (ack !== 1'b1) errors++;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask

    // direct pin check against a rule level
    task automatic chk(input logic g, input logic e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wrap_up();
        if (errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // compares read data against the oldest noted value
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0) begin
            checks++;
            if (rdat !== expq[0]) begin
                errors++;
                $display("wrong value at %0t: got %h expected %h", $time, rdat, expq[0]);
            end
            expq.delete(0);
        end
    end

    initial begin
        idle(30000);
        errors++;
        wrap_up();
    end

    initial begin
        idle(16);
        rst_i <= 1'b0;
        rd(TMR8_CTRL_OFS, 32'h0);
        rd(TMR8_DIR_OFS, 32'h0);
        rd(TMR8_FLAG_OFS, 32'h0);
        rd(5'h18, 32'h0);
        wr(TMR8_CMPA_OFS, 32'h9);
        wr(TMR8_CTRL_OFS, 32'h12);
        idle(40);
        wr(TMR8_FLAG_OFS, 32'h7);
        idle(60);
        rd(TMR8_FLAG_OFS, 32'h6);
        wr(TMR8_CTRL_OFS, 32'h2);
        wr(TMR8_CNT_OFS, 32'h14);
        wr(TMR8_FLAG_OFS, 32'h7);
        wr(TMR8_CTRL_OFS, 32'h12);
        idle(100);
        rd(TMR8_FLAG_OFS, 32'h0);
        idle(250);
        rd(TMR8_FLAG_OFS, 32'h7);
        foreach (modes[i]) begin
            wr(TMR8_CTRL_OFS, {29'h0, modes[i]});
            wr(TMR8_CMPA_OFS, 32'h9);
            wr(TMR8_CNT_OFS, 32'h0);
            wr(TMR8_FLAG_OFS, 32'h7);
            wr(TMR8_CTRL_OFS, {28'h1, 1'b0, modes[i]});
            idle(600);
            rd(TMR8_FLAG_OFS, 32'h7);
        end
        wr(TMR8_CTRL_OFS, 32'h14);
        repeat (3) begin
            rng = xs(rng);
            wr(TMR8_CNT_OFS, {24'h0, rng[7:0]});
            idle(20);
            rd(TMR8_CNT_OFS, {24'h0, rng[7:0]});
        end
        wr(TMR8_CTRL_OFS, 32'h813);
        wr(TMR8_CMPA_OFS, 32'hFF);
        idle(600);
        rd(TMR8_DIR_OFS, 32'h4);
        idle(97);
        rd(TMR8_DIR_OFS, 32'h4);
        wr(TMR8_CTRL_OFS, 32'hC13);
        idle(600);
        rd(TMR8_DIR_OFS, 32'h0);
        wr(TMR8_CTRL_OFS, 32'h811);
        wr(TMR8_CMPA_OFS, 32'h0);
        idle(1100);
        rd(TMR8_DIR_OFS, 32'h0);
        wr(TMR8_CTRL_OFS, 32'hC11);
        idle(1100);
        rd(TMR8_DIR_OFS, 32'h4);
        chk(oe_a_n, 1'b1);
        wr(TMR8_DIR_OFS, 32'h1);
        wr(TMR8_CTRL_OFS, 32'h412);
        wr(TMR8_CMPA_OFS, 32'h0);
        idle(400);
        chk(oe_a_n, 1'b0);
        wr(TMR8_CTRL_OFS, 32'h3);
        wr(TMR8_CNT_OFS, 32'h0);
        wr(TMR8_FLAG_OFS, 32'h7);
        wr(TMR8_CTRL_OFS, 32'h23);
        idle(1500);
        rd(TMR8_FLAG_OFS, 32'h0);
        idle(700);
        rd(TMR8_FLAG_OFS, 32'h7);
        chk(ovf, 1'b1);
        chk(flag_a, 1'b1);
        chk(wave_b, 1'b0);
        chk(oe_b_n, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
